// File: include/sxs_defines.svh
// Offsets, fields, reset values and op codes of the execution block
`ifndef SXS_DEFINES_SVH
`define SXS_DEFINES_SVH
`define SXS_A_ACC       12'h000
`define SXS_A_STATUS    12'h004
`define SXS_A_INSTR     12'h008
`define SXS_A_DIR_A     12'h00C
`define SXS_A_DIR_B     12'h010
`define SXS_A_DIR_C     12'h014
`define SXS_A_WDT       12'h018
`define SXS_A_FILE_HI   3'h1
`define SXS_I_OP_LSB    0
`define SXS_I_D         4
`define SXS_I_F_LSB     5
`define SXS_I_K_LSB     12
`define SXS_S_C         0
`define SXS_S_DC        1
`define SXS_S_Z         2
`define SXS_S_PD        3
`define SXS_S_TO        4
`define SXS_S_SLEEP     5
`define SXS_W_PRE_LSB   8
`define SXS_OP_NOP      4'h0
`define SXS_OP_SUB      4'h1
`define SXS_OP_SUBB     4'h2
`define SXS_OP_SWAP     4'h3
`define SXS_OP_XORL     4'h4
`define SXS_OP_XORF     4'h5
`define SXS_OP_DIR      4'h6
`define SXS_OP_SLEEP    4'h7
`define SXS_F_DIR_A     7'h05
`define SXS_F_DIR_B     7'h06
`define SXS_F_DIR_C     7'h07
`define SXS_RST_DIR     8'hFF
`define SXS_RST_TO      1'b1
`define SXS_RST_PD      1'b1
`define SXS_WDT_CLR     8'h00
`endif

// File: include/sxs_pkg.sv
// Types of the execution block
package sxs_pkg;
  typedef enum logic {
    SXS_RUN,
    SXS_ASLEEP
  } sxs_mode_t;

  typedef struct packed {
    logic [7:0]        acc;
    logic              c;
    logic              dc;
    logic              z;
    logic              to;
    logic              pd;
    sxs_mode_t         mode;
    logic [7:0]        dir_a;
    logic [7:0]        dir_b;
    logic [7:0]        dir_c;
    logic [7:0]        wdt;
    logic [7:0]        pre;
    logic [127:0][7:0] file;
    logic              ap_valid;
    logic              ap_write;
    logic [11:0]       ap_addr;
    logic [31:0]       rdata;
    logic              wk_meta;
    logic              wk_sync;
  } sxs_state_t;
endpackage

// File: rtl/sxs_exec.sv
// Execution unit for subtract, swap, xor, direction load and sleep
//
// Operation
// - Sleep zeroes watchdog and prescaler, sets expiry, clears power-down.
// - After sleep the oscillator halts; nothing executes until wake-up.
// - Subtract gives file register minus accumulator; file index is 7 bits.
// - Destination bit 0 writes accumulator, 1 writes the file register.
// - Carry set unless accumulator larger; digit carry likewise per nibble.
// - Borrow subtract also removes inverted carry; sets carry, digit, zero.
// - Nibble exchange swaps halves into chosen destination, flags untouched.
// - Xor literal mixes accumulator with 8-bit immediate; updates only zero.
// - Xor file mixes accumulator with file into destination; zero only.
// - Direction load copies accumulator to port A, B or C for 5, 6, 7.
`timescale 1ns/1ns
`include "sxs_defines.svh"

module sxs_exec (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  input  wire logic        wake_in,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic [7:0]       port_a_direction,
  output logic [7:0]       port_b_direction,
  output logic [7:0]       port_c_direction,
  output logic             sleep_mode,
  output logic             osc_run
);

  sxs_pkg::sxs_state_t st;
  sxs_pkg::sxs_state_t next_st;

  logic        ap_take;
  logic        ap_hit;
  logic        dp_wr;
  logic        ex_go;
  logic [3:0]  ex_op;
  logic        ex_d;
  logic [6:0]  ex_f;
  logic [7:0]  ex_k;
  logic [7:0]  f_val;
  logic        cin;
  logic [8:0]  sum9;
  logic [4:0]  nib5;
  logic [7:0]  result;
  logic [31:0] rd_mux;
  logic        is_sub;
  logic        is_subb;
  logic        is_swap;
  logic        is_xorl;
  logic        is_xorf;
  logic        is_dir;
  logic        is_sleep;
  logic [7:0]  sub_ref;
  logic [7:0]  subb_ref;
  logic        ge_ref;
  logic        nib_ge_ref;
  logic        wr_file_hit;
  logic        subb_ge_ref;
  logic        subb_nib_ref;

  // Bus address phase
  assign ap_take = hsel & htrans[1] & hready;
  assign ap_hit  = (haddr[31:12] == 20'h00000);
  assign dp_wr   = st.ap_valid & st.ap_write;

  // Instruction word fields
  assign ex_op = hwdata[`SXS_I_OP_LSB +: 4];
  assign ex_d  = hwdata[`SXS_I_D];
  assign ex_f  = hwdata[`SXS_I_F_LSB +: 7];
  assign ex_k  = hwdata[`SXS_I_K_LSB +: 8];
  assign ex_go = dp_wr && (st.ap_addr == `SXS_A_INSTR)
                 && (st.mode == sxs_pkg::SXS_RUN);

  assign is_sub   = ex_go && (ex_op == `SXS_OP_SUB);
  assign is_subb  = ex_go && (ex_op == `SXS_OP_SUBB);
  assign is_swap  = ex_go && (ex_op == `SXS_OP_SWAP);
  assign is_xorl  = ex_go && (ex_op == `SXS_OP_XORL);
  assign is_xorf  = ex_go && (ex_op == `SXS_OP_XORF);
  assign is_dir   = ex_go && (ex_op == `SXS_OP_DIR);
  assign is_sleep = ex_go && (ex_op == `SXS_OP_SLEEP);

  // Operand fetch by 7-bit index
  assign f_val = st.file[ex_f];

  // Two's complement subtract as f + ~w + carry-in
  assign cin  = (ex_op == `SXS_OP_SUBB) ? st.c : 1'b1;
  assign sum9 = {1'b0, f_val} + {1'b0, ~st.acc} + {8'h00, cin};
  assign nib5 = {1'b0, f_val[3:0]} + {1'b0, ~st.acc[3:0]}
                + {4'h0, cin};

  always_comb begin
    case (ex_op)
      `SXS_OP_SUB:  result = sum9[7:0];
      `SXS_OP_SUBB: result = sum9[7:0];
      `SXS_OP_SWAP: result = {f_val[3:0], f_val[7:4]};
      `SXS_OP_XORL: result = st.acc ^ ex_k;
      `SXS_OP_XORF: result = st.acc ^ f_val;
      default:      result = 8'h00;
    endcase
  end

  // Read data selected in the address phase
  always_comb begin
    rd_mux = 32'h00000000;
    if (!ap_hit) begin
      rd_mux = 32'h00000000;
    end else if (haddr[11:9] == `SXS_A_FILE_HI) begin
      rd_mux = {24'h000000, st.file[haddr[8:2]]};
    end else begin
      case (haddr[11:0])
        `SXS_A_ACC:    rd_mux = {24'h000000, st.acc};
        `SXS_A_STATUS: begin
          rd_mux[`SXS_S_C]     = st.c;
          rd_mux[`SXS_S_DC]    = st.dc;
          rd_mux[`SXS_S_Z]     = st.z;
          rd_mux[`SXS_S_PD]    = st.pd;
          rd_mux[`SXS_S_TO]    = st.to;
          rd_mux[`SXS_S_SLEEP] = (st.mode == sxs_pkg::SXS_ASLEEP);
        end
        `SXS_A_DIR_A:  rd_mux = {24'h000000, st.dir_a};
        `SXS_A_DIR_B:  rd_mux = {24'h000000, st.dir_b};
        `SXS_A_DIR_C:  rd_mux = {24'h000000, st.dir_c};
        `SXS_A_WDT:    rd_mux = {16'h0000, st.pre, st.wdt};
        default:       rd_mux = 32'h00000000;
      endcase
    end
  end

  // Next state
  always_comb begin
    next_st = st;
    next_st.wk_meta  = wake_in;
    next_st.wk_sync  = st.wk_meta;
    next_st.ap_valid = ap_take & ap_hit;
    next_st.ap_write = hwrite;
    next_st.ap_addr  = haddr[11:0];
    next_st.rdata    = (ap_take && !hwrite) ? rd_mux : 32'h00000000;

    // Data phase register writes
    if (dp_wr) begin
      if (st.ap_addr[11:9] == `SXS_A_FILE_HI) begin
        next_st.file[st.ap_addr[8:2]] = hwdata[7:0];
      end else begin
        case (st.ap_addr)
          `SXS_A_ACC: next_st.acc = hwdata[7:0];
          `SXS_A_STATUS: begin
            next_st.c  = hwdata[`SXS_S_C];
            next_st.dc = hwdata[`SXS_S_DC];
            next_st.z  = hwdata[`SXS_S_Z];
          end
          `SXS_A_WDT: begin
            next_st.wdt = hwdata[7:0];
            next_st.pre = hwdata[`SXS_W_PRE_LSB +: 8];
          end
          default: next_st.acc = st.acc;
        endcase
      end
    end

    // Instruction execution
    if (ex_go) begin
      case (ex_op)
        `SXS_OP_SUB, `SXS_OP_SUBB: begin
          if (ex_d) begin
            next_st.file[ex_f] = result;
          end else begin
            next_st.acc = result;
          end
          next_st.c  = sum9[8];
          next_st.dc = nib5[4];
          next_st.z  = (result == 8'h00);
        end
        `SXS_OP_SWAP, `SXS_OP_XORF: begin
          if (ex_d) begin
            next_st.file[ex_f] = result;
          end else begin
            next_st.acc = result;
          end
          if (ex_op == `SXS_OP_XORF) begin
            next_st.z = (result == 8'h00);
          end
        end
        `SXS_OP_XORL: begin
          next_st.acc = result;
          next_st.z   = (result == 8'h00);
        end
        `SXS_OP_DIR: begin
          case (ex_f)
            `SXS_F_DIR_A: next_st.dir_a = st.acc;
            `SXS_F_DIR_B: next_st.dir_b = st.acc;
            `SXS_F_DIR_C: next_st.dir_c = st.acc;
            default:      next_st.dir_a = st.dir_a;
          endcase
        end
        `SXS_OP_SLEEP: begin
          next_st.wdt  = `SXS_WDT_CLR;
          next_st.pre  = `SXS_WDT_CLR;
          next_st.to   = 1'b1;
          next_st.pd   = 1'b0;
          next_st.mode = sxs_pkg::SXS_ASLEEP;
        end
        default: next_st.acc = st.acc;
      endcase
    end

    // Wake-up from synchronised pin
    if (st.mode == sxs_pkg::SXS_ASLEEP && st.wk_sync) begin
      next_st.mode = sxs_pkg::SXS_RUN;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st       <= '0;
      st.to    <= `SXS_RST_TO;
      st.pd    <= `SXS_RST_PD;
      st.dir_a <= `SXS_RST_DIR;
      st.dir_b <= `SXS_RST_DIR;
      st.dir_c <= `SXS_RST_DIR;
      st.mode  <= sxs_pkg::SXS_RUN;
    end else begin
      st <= next_st;
    end
  end

  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign hrdata           = st.rdata;
  assign port_a_direction = st.dir_a;
  assign port_b_direction = st.dir_b;
  assign port_c_direction = st.dir_c;
  assign sleep_mode       = (st.mode == sxs_pkg::SXS_ASLEEP);
  assign osc_run          = (st.mode == sxs_pkg::SXS_RUN);

  // Reference values for checking
  assign sub_ref     = f_val - st.acc;
  assign subb_ref    = f_val - st.acc - {7'h00, ~st.c};
  assign ge_ref      = (st.acc <= f_val);
  assign nib_ge_ref  = (st.acc[3:0] <= f_val[3:0]);
  assign wr_file_hit = dp_wr && (st.ap_addr[11:9] == `SXS_A_FILE_HI);
  assign subb_ge_ref = ({1'b0, f_val} >= ({1'b0, st.acc} + {8'h00, ~st.c}));
  assign subb_nib_ref = ({1'b0, f_val[3:0]}
                        >= ({1'b0, st.acc[3:0]} + {4'h0, ~st.c}));

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_sleep_side_effects: assert property (
    is_sleep |=> (st.wdt == 8'h00) && (st.pre == 8'h00)
                 && st.to && !st.pd)
    else $error("sleep did not clear watchdog or set flags");

  a_sleep_halts_core: assert property (
    is_sleep ##1 !st.wk_sync |=> sleep_mode && !osc_run
                                 && $stable(st.acc))
    else $error("core ran after sleep");

  a_sub_to_acc: assert property (
    is_sub && !ex_d |=> st.acc == $past(sub_ref))
    else $error("subtract result to accumulator wrong");

  a_sub_to_file: assert property (
    (is_sub || is_subb) && ex_d |=>
      st.file[$past(ex_f)] == $past(is_sub ? sub_ref : subb_ref)
      && $stable(st.acc))
    else $error("subtract result not stored in file register");

  a_sub_carries: assert property (
    is_sub |=> st.c == $past(ge_ref) && st.dc == $past(nib_ge_ref))
    else $error("subtract carry or digit carry wrong");

  a_subb_result: assert property (
    is_subb && !ex_d |=> st.acc == $past(subb_ref))
    else $error("borrow subtract result wrong");

  a_subb_carries: assert property (
    is_subb |=> st.c == $past(subb_ge_ref)
                && st.dc == $past(subb_nib_ref))
    else $error("borrow subtract carry or digit carry wrong");

  a_swap_nibbles: assert property (
    is_swap && !ex_d |=>
      st.acc == {$past(f_val[3:0]), $past(f_val[7:4])}
      && $stable(st.c) && $stable(st.dc) && $stable(st.z))
    else $error("nibble exchange wrong or flags changed");

  a_swap_to_file: assert property (
    is_swap && ex_d |=>
      st.file[$past(ex_f)] == {$past(f_val[3:0]), $past(f_val[7:4])}
      && $stable(st.acc) && $stable(st.z))
    else $error("nibble exchange to file wrong");

  a_xor_literal: assert property (
    is_xorl |=> st.acc == ($past(st.acc) ^ $past(ex_k))
                && $stable(st.c) && $stable(st.dc))
    else $error("xor literal wrong");

  a_xor_file: assert property (
    is_xorf && ex_d |=>
      st.file[$past(ex_f)] == ($past(st.acc) ^ $past(f_val))
      && $stable(st.acc) && $stable(st.c))
    else $error("xor with file wrong");

  a_xor_file_acc: assert property (
    is_xorf && !ex_d |=>
      st.acc == ($past(st.acc) ^ $past(f_val))
      && $stable(st.c) && $stable(st.dc))
    else $error("xor with file into accumulator wrong");

  a_dir_load: assert property (
    is_dir && ex_f == 7'h06 |=>
      port_b_direction == $past(st.acc) && $stable(port_a_direction)
      && $stable(st.z))
    else $error("direction load wrong");

  a_dir_load_a: assert property (
    is_dir && ex_f == 7'h05 |=>
      port_a_direction == $past(st.acc) && $stable(port_c_direction))
    else $error("port A direction load wrong");

  a_dir_load_c: assert property (
    is_dir && ex_f == 7'h07 |=>
      port_c_direction == $past(st.acc) && $stable(port_b_direction))
    else $error("port C direction load wrong");

  a_dir_bad_index: assert property (
    is_dir && (ex_f > 7'h07 || ex_f < 7'h05) |=>
      $stable(port_a_direction) && $stable(port_b_direction)
      && $stable(port_c_direction))
    else $error("direction load with bad index changed a port");

  a_asleep_no_exec: assert property (
    dp_wr && (st.ap_addr == `SXS_A_INSTR) && sleep_mode |=>
      $stable(st.acc) && $stable(st.z) && $stable(st.c)
      && $stable(port_a_direction))
    else $error("instruction executed while asleep");

  a_zero_flag: assert property (
    (is_sub || is_subb || is_xorl || is_xorf) && !wr_file_hit |=>
      st.z == (($past(ex_d) && !$past(is_xorl))
               ? (st.file[$past(ex_f)] == 8'h00)
               : (st.acc == 8'h00)))
    else $error("zero flag does not follow result");

endmodule // sxs_exec

// File: testbench/tb.sv
// Self-checking testbench of the execution block
`timescale 1ns/1ns
`include "sxs_defines.svh"

module tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        wake_in = 1'b0;
  logic        hreadyout;
  logic        hresp;
  logic        sleep_mode;
  logic        osc_run;
  logic [31:0] hrdata;
  logic [7:0]  dir_a;
  logic [7:0]  dir_b;
  logic [7:0]  dir_c;
  logic [31:0] exp_q[$];
  logic        rd_dp = 1'b0;
  int          n_mismatch = 0;
  int          checks = 0;
  int          cyc = 0;
  logic [7:0]  w, fv, k, r;
  logic [7:0]  dv [3];
  logic [6:0]  f;
  logic [3:0]  op;
  logic        d, c, dc, z, ci;

  sxs_exec i_dut (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .hsel             (hsel),
    .haddr            (haddr),
    .htrans           (htrans),
    .hwrite           (hwrite),
    .hsize            (hsize),
    .hready           (hreadyout),
    .hwdata           (hwdata),
    .wake_in          (wake_in),
    .hreadyout        (hreadyout),
    .hresp            (hresp),
    .hrdata           (hrdata),
    .port_a_direction (dir_a),
    .port_b_direction (dir_b),
    .port_c_direction (dir_c),
    .sleep_mode       (sleep_mode),
    .osc_run          (osc_run)
  );

  always #25 hclk = ~hclk;

  task automatic summarize();
    if (n_mismatch == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic [31:0] a, input logic wr,
                     input logic [31:0] dat);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= dat;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] dat);
    bus(a, 1'b1, dat);
    @(posedge hclk);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask

  // Read data checked in the data phase
  always @(posedge hclk) begin
    cyc++;
    if (rd_dp) chk(hrdata, exp_q.pop_front());
    if (rd_dp) chk({31'h0, hresp}, 32'h0);
    rd_dp = hsel & htrans[1] & ~hwrite & hreadyout;
    if (cyc == 5000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    void'($urandom(98961));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd(32'(`SXS_A_STATUS), 32'h18);
    for (int i = 0; i < 3; i++) rd(32'(`SXS_A_DIR_A) + 4 * i, 32'hFF);
    for (int n = 0; n < 40; n++) begin
      op = 4'(n % 5 + 1);
      w = 8'($urandom);
      fv = (n % 4 == 0) ? w : 8'($urandom);
      {k, d} = 9'($urandom);
      f = (n == 39) ? 7'h7F : 7'($urandom);
      {z, dc, c} = 3'($urandom);
      wr(32'(`SXS_A_ACC), {24'h0, w});
      wr(32'h200 + 4 * f, {24'h0, fv});
      wr(32'(`SXS_A_STATUS), {29'h0, z, dc, c});
      wr(32'(`SXS_A_INSTR), {12'h0, k, f, d, op});
      ci = (op == `SXS_OP_SUB) ? 1'b1 : c;
      case (op)
        `SXS_OP_SUB, `SXS_OP_SUBB: begin
          r = fv - w - 8'(!ci);
          c = ({1'b0, fv} >= {1'b0, w} + 9'(!ci));
          dc = ({1'b0, fv[3:0]} >= {1'b0, w[3:0]} + 5'(!ci));
        end
        `SXS_OP_SWAP: r = {fv[3:0], fv[7:4]};
        `SXS_OP_XORL: r = w ^ k;
        default: r = w ^ fv;
      endcase
      if (op != `SXS_OP_SWAP) z = (r == 8'h0);
      if (op == `SXS_OP_XORL) d = 1'b0;
      rd(32'(`SXS_A_ACC), {24'h0, d ? w : r});
      rd(32'h200 + 4 * f, {24'h0, d ? r : fv});
      rd(32'(`SXS_A_STATUS), {26'h0, 3'b011, z, dc, c});
    end
    for (int i = 5; i < 9; i++) begin
      w = 8'($urandom);
      wr(32'(`SXS_A_ACC), {24'h0, w});
      wr(32'(`SXS_A_INSTR), {20'h0, 7'(i), 1'b0, `SXS_OP_DIR});
      if (i < 8) dv[i - 5] = w;
    end
    for (int i = 0; i < 3; i++) begin
      rd(32'(`SXS_A_DIR_A) + 4 * i, {24'h0, dv[i]});
    end
    chk({8'h0, dir_a, dir_b, dir_c}, {8'h0, dv[0], dv[1], dv[2]});
    rd(32'(`SXS_A_STATUS), {26'h0, 3'b011, z, dc, c});
    wr(32'(`SXS_A_WDT), 32'hC35A);
    wr(32'(`SXS_A_INSTR), {28'h0, `SXS_OP_SLEEP});
    rd(32'(`SXS_A_WDT), 32'h0);
    rd(32'(`SXS_A_STATUS), {26'h0, 3'b110, z, dc, c});
    chk({30'h0, sleep_mode, osc_run}, 32'h2);
    wr(32'(`SXS_A_INSTR), {12'h0, 8'hFF, 8'h0, `SXS_OP_XORL});
    rd(32'(`SXS_A_ACC), {24'h0, w});
    wake_in <= 1'b1;
    repeat (4) @(posedge hclk);
    chk({30'h0, sleep_mode, osc_run}, 32'h1);
    wake_in <= 1'b0;
    wr(32'(`SXS_A_INSTR), {12'h0, 8'hFF, 8'h0, `SXS_OP_XORL});
    rd(32'(`SXS_A_ACC), {24'h0, ~w});
    wr(32'h100, 32'h5A);
    rd(32'h100, 32'h0);
    rd(32'h1200, 32'h0);
    repeat (2) @(posedge hclk);
    summarize();
  end
endmodule // tb
